// ===== verilog/pes_pkg.sv
// Package for the precise event sample capture block: map, layout, types
`default_nettype none
package pes_pkg;
   // Sizes
   localparam int NUM_CTR = 4;
   localparam int CTR_W = 48;
   localparam int LAT_W = 16;
   localparam int NUM_GPR = 16;
   localparam int NUM_LEGACY_GPR = 8;
   // Sample record layout, byte offsets
   localparam int RB_FLAGS = 'h00;
   localparam int RB_IP = 'h08;
   localparam int RB_GPR0 = 'h10;
   localparam int RB_STATUS = 'h90;
   localparam int RB_DADDR = 'h98;
   localparam int RB_DSRC = 'ha0;
   localparam int RB_LAT = 'ha8;
   localparam int W_FLAGS = RB_FLAGS / 8;
   localparam int W_IP = RB_IP / 8;
   localparam int W_GPR0 = RB_GPR0 / 8;
   localparam int W_STATUS = RB_STATUS / 8;
   localparam int W_DADDR = RB_DADDR / 8;
   localparam int W_DSRC = RB_DSRC / 8;
   localparam int W_LAT = RB_LAT / 8;
   localparam int REC_WORDS = W_LAT + 1;
   localparam logic [4:0] LAST_WORD = 5'(REC_WORDS - 1);
   localparam logic [63:0] WORD_STEP = 64'h0000_0000_0000_0008;
   localparam logic [63:0] REC_STRIDE = 64'(REC_WORDS * 8);
   // Register byte addresses
   localparam logic [7:0] A_CAP = 8'h00;
   localparam logic [7:0] A_IDENT = 8'h04;
   localparam logic [7:0] A_MISC = 8'h08;
   localparam logic [7:0] A_SEN_LO = 8'h0c;
   localparam logic [7:0] A_SEN_HI = 8'h10;
   localparam logic [7:0] A_STAT_LO = 8'h14;
   localparam logic [7:0] A_STAT_HI = 8'h18;
   localparam logic [7:0] A_EVSEL0 = 8'h1c;
   localparam logic [7:0] A_CTR0 = 8'h30;
   localparam logic [7:0] A_BASE = 8'h50;
   localparam logic [7:0] A_INDEX = 8'h58;
   localparam logic [7:0] A_ABSMAX = 8'h60;
   localparam logic [7:0] A_THRESH = 8'h68;
   localparam logic [7:0] A_RST0 = 8'h70;
   // Field positions and fixed values
   localparam int CAP_FMT_LSB = 8;
   localparam logic [3:0] CAP_FMT_ENH = 4'h1;
   localparam int CAP_ASSIST_BIT = 6;
   localparam int ID_WIDTH_LSB = 16;
   localparam int ID_NCTR_LSB = 8;
   localparam int ID_WIDE_BIT = 2;
   localparam int MISC_PERF_BIT = 7;
   localparam int MISC_NOSAMPLE_BIT = 12;
   localparam int EVSEL_EN_BIT = 22;
   localparam int STAT_BUF_HI_BIT = 30;
   localparam int STAT_BUF_BIT = 62;

   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_FINISH} pes_fsm_t;

   // Retired machine state offered by the core
   typedef struct packed {
      logic [63:0] flags;
      logic [63:0] next_ip;
      logic [NUM_GPR-1:0][63:0] gpr;
      logic long_mode;
      logic [63:0] data_addr;
      logic [63:0] data_src;
   } pes_retire_t;

   // One record word towards memory
   typedef struct packed {
      logic [63:0] addr;
      logic [63:0] data;
   } pes_mem_wr_t;
endpackage
`default_nettype wire

// ===== verilog/pes_sample_capture.sv
// Precise event sampling: counters, arming, record writer, register slave
// Notes on behaviour
// - General counters are 48 bits; identity register reports that width.
// - Four counters, each with its own select register, all sample capable.
// - Four sample enable bits choose which overflow leads to a record.
// - Four latency enable bits choose whether latency is recorded.
// - Wrap of an enabled counter arms sampling, captures nothing yet.
// - Next precise event after arming writes one record to the buffer.
// - Capability bits 11:8 read 0001b, the enhanced record format.
// - Capability bit 6 reports the assist behaviour.
// - Recorded instruction pointer is that of the following instruction.
// - Recorded registers show state after the causing instruction retired.
// - Record words are 64 bits: flags, pointer, sixteen registers to 88h.
// - Status at 90h, data address 98h, source a0h, latency a8h.
// - Record layout identical in and outside 64-bit mode.
// - Outside 64-bit mode upper halves of flags, pointer, registers and data address, and upper registers, are zero.
// - Status word holds overflow status as it stood before the assist.
// - Identity bit 2 reports mode-independent wide store format.
// - Misc enable bits 7 and 12 report monitoring and sampling support.
// - Latency counts core cycles from first dispatch to final writeback.
// - Index advances per record; full buffer drops records silently.
// - Index reaching threshold raises interrupt and sets the buffer flag.
// - After a record, overflowed sampling counters reload their reset value.
`timescale 1ns/10ps
`default_nettype none
module pes_sample_capture
   import pes_pkg::*;
#(
   parameter logic ASSIST_TRAP_LIKE = 1'b1
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Avalon-MM register slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Core events and retired state
   input wire logic [NUM_CTR-1:0] EVENT_I,
   input wire logic [NUM_CTR-1:0] PRECISE_I,
   input wire pes_retire_t RETIRE_I,
   input wire logic LOAD_DISPATCH_I,
   input wire logic LOAD_WRITEBACK_I,
   // Record write port
   output pes_mem_wr_t MEM_WR_O,
   output logic MEM_WRITE_O,
   input wire logic MEM_READY_I,
   // Performance interrupt
   output logic PMI_O
);

   typedef struct packed {
      pes_fsm_t fsm;
      logic waitreq;
      logic [31:0] rdata;
      logic [NUM_CTR-1:0][CTR_W-1:0] ctr;
      logic [NUM_CTR-1:0][31:0] evsel;
      logic [NUM_CTR-1:0] sen;
      logic [NUM_CTR-1:0] len;
      logic [NUM_CTR-1:0] ovf;
      logic buf_flag;
      logic [NUM_CTR-1:0] armed;
      logic [63:0] base;
      logic [63:0] index;
      logic [63:0] absmax;
      logic [63:0] thresh;
      logic [NUM_CTR-1:0][CTR_W-1:0] rst_val;
      logic [REC_WORDS-1:0][63:0] rec;
      logic [4:0] word;
      pes_mem_wr_t mem;
      logic mem_write;
      logic pmi;
      logic lat_busy;
      logic [LAT_W-1:0] lat_cnt;
      logic [LAT_W-1:0] lat_last;
   } pes_state_t;

   pes_state_t s;
   pes_state_t next_s;
   logic wr;
   logic [31:0] rd;
   logic [NUM_CTR-1:0] trig;
   logic [NUM_CTR-1:0] ovf_set;
   logic [NUM_CTR-1:0] ovf_clr;
   logic buf_set;
   logic buf_clr;
   logic [1:0] sel;
   logic [REC_WORDS-1:0][63:0] rec_new;
   logic [4:0] nxt_word;
   logic [7:0] ca;
   logic [63:0] new_index;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [63:0] narrow(input logic [63:0] v, input logic lm);
      return lm ? v : {32'h0, v[31:0]};
   endfunction

   always_comb begin
      next_s = s;
      next_s.pmi = 1'b0;
      rd = '0;
      ca = '0;
      sel = '0;
      ovf_set = '0;
      ovf_clr = '0;
      buf_set = 1'b0;
      buf_clr = 1'b0;
      nxt_word = s.word + 5'h1;
      new_index = s.index + REC_STRIDE;
      wr = AVS_WRITE_I && !s.waitreq;
      // Answer one cycle after the request is seen
      next_s.waitreq = !((AVS_READ_I || AVS_WRITE_I) && s.waitreq);
      case (AVS_ADDRESS_I)
         A_CAP: rd = 32'({CAP_FMT_ENH, 8'h00}) | (32'(ASSIST_TRAP_LIKE) << CAP_ASSIST_BIT);
         A_IDENT: rd = (32'(CTR_W) << ID_WIDTH_LSB) | (32'(NUM_CTR) << ID_NCTR_LSB)
                       | (32'h1 << ID_WIDE_BIT);
         A_MISC: rd = (32'h1 << MISC_PERF_BIT) & ~(32'h1 << MISC_NOSAMPLE_BIT);
         A_SEN_LO: rd = 32'(s.sen);
         A_SEN_HI: rd = 32'(s.len);
         A_STAT_LO: rd = 32'(s.ovf);
         A_STAT_HI: rd = 32'(s.buf_flag) << STAT_BUF_HI_BIT;
         A_BASE: rd = s.base[31:0];
         A_BASE + 8'h4: rd = s.base[63:32];
         A_INDEX: rd = s.index[31:0];
         A_INDEX + 8'h4: rd = s.index[63:32];
         A_ABSMAX: rd = s.absmax[31:0];
         A_ABSMAX + 8'h4: rd = s.absmax[63:32];
         A_THRESH: rd = s.thresh[31:0];
         A_THRESH + 8'h4: rd = s.thresh[63:32];
         default: rd = '0;
      endcase
      for (int i = 0; i < NUM_CTR; i++) begin
         if (s.evsel[i][EVSEL_EN_BIT] && EVENT_I[i]) begin
            next_s.ctr[i] = s.ctr[i] + 48'h1;
            if (&s.ctr[i]) begin
               ovf_set[i] = 1'b1;
               if (s.sen[i]) begin
                  next_s.armed[i] = 1'b1;
               end
            end
         end
         trig[i] = s.armed[i] && PRECISE_I[i];
         ca = A_EVSEL0 + 8'(i * 4);
         if (AVS_ADDRESS_I == ca) begin
            rd = s.evsel[i];
         end
         if (wr && AVS_ADDRESS_I == ca) begin
            next_s.evsel[i] = merge(s.evsel[i], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         // Counters are 48 bits, split over two words
         ca = A_CTR0 + 8'(i * 8);
         if (AVS_ADDRESS_I == ca) begin
            rd = s.ctr[i][31:0];
         end
         if (AVS_ADDRESS_I == ca + 8'h4) begin
            rd = {16'h0, s.ctr[i][CTR_W-1:32]};
         end
         if (wr && AVS_ADDRESS_I == ca) begin
            next_s.ctr[i][31:0] = merge(s.ctr[i][31:0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         if (wr && AVS_ADDRESS_I == ca + 8'h4) begin
            next_s.ctr[i][CTR_W-1:32] = 16'(merge({16'h0, s.ctr[i][CTR_W-1:32]},
                                                  AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
         end
         ca = A_RST0 + 8'(i * 8);
         if (AVS_ADDRESS_I == ca) begin
            rd = s.rst_val[i][31:0];
         end
         if (AVS_ADDRESS_I == ca + 8'h4) begin
            rd = {16'h0, s.rst_val[i][CTR_W-1:32]};
         end
         if (wr && AVS_ADDRESS_I == ca) begin
            next_s.rst_val[i][31:0] = merge(s.rst_val[i][31:0], AVS_WRITEDATA_I,
                                            AVS_BYTEENABLE_I);
         end
         if (wr && AVS_ADDRESS_I == ca + 8'h4) begin
            next_s.rst_val[i][CTR_W-1:32] = 16'(merge({16'h0, s.rst_val[i][CTR_W-1:32]},
                                                      AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
         end
      end
      if (AVS_READ_I && s.waitreq) begin
         next_s.rdata = rd;
      end
      if (wr) begin
         case (AVS_ADDRESS_I)
            A_SEN_LO: next_s.sen = NUM_CTR'(merge(32'(s.sen), AVS_WRITEDATA_I,
                                                  AVS_BYTEENABLE_I));
            A_SEN_HI: next_s.len = NUM_CTR'(merge(32'(s.len), AVS_WRITEDATA_I,
                                                  AVS_BYTEENABLE_I));
            A_STAT_LO: ovf_clr = NUM_CTR'(merge(32'h0, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            A_STAT_HI: buf_clr = AVS_BYTEENABLE_I[STAT_BUF_HI_BIT / 8]
                                 && AVS_WRITEDATA_I[STAT_BUF_HI_BIT];
            A_BASE: next_s.base[31:0] = merge(s.base[31:0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            A_BASE + 8'h4: next_s.base[63:32] = merge(s.base[63:32], AVS_WRITEDATA_I,
                                                      AVS_BYTEENABLE_I);
            A_INDEX: next_s.index[31:0] = merge(s.index[31:0], AVS_WRITEDATA_I,
                                                AVS_BYTEENABLE_I);
            A_INDEX + 8'h4: next_s.index[63:32] = merge(s.index[63:32], AVS_WRITEDATA_I,
                                                        AVS_BYTEENABLE_I);
            A_ABSMAX: next_s.absmax[31:0] = merge(s.absmax[31:0], AVS_WRITEDATA_I,
                                                  AVS_BYTEENABLE_I);
            A_ABSMAX + 8'h4: next_s.absmax[63:32] = merge(s.absmax[63:32], AVS_WRITEDATA_I,
                                                          AVS_BYTEENABLE_I);
            A_THRESH: next_s.thresh[31:0] = merge(s.thresh[31:0], AVS_WRITEDATA_I,
                                                  AVS_BYTEENABLE_I);
            A_THRESH + 8'h4: next_s.thresh[63:32] = merge(s.thresh[63:32], AVS_WRITEDATA_I,
                                                          AVS_BYTEENABLE_I);
            default: ;
         endcase
      end
      // Latency from first dispatch to writeback, re-dispatch included
      if (s.lat_busy) begin
         next_s.lat_cnt = s.lat_cnt + 16'h1;
         if (LOAD_WRITEBACK_I) begin
            next_s.lat_busy = 1'b0;
            next_s.lat_last = s.lat_cnt + 16'h1;
         end
      end else if (LOAD_DISPATCH_I) begin
         next_s.lat_busy = 1'b1;
         next_s.lat_cnt = '0;
      end

      for (int i = NUM_CTR - 1; i >= 0; i--) begin
         if (trig[i]) begin
            sel = 2'(i);
         end
      end

      rec_new = '0;
      rec_new[W_FLAGS] = narrow(RETIRE_I.flags, RETIRE_I.long_mode);
      rec_new[W_IP] = narrow(RETIRE_I.next_ip, RETIRE_I.long_mode);
      for (int g = 0; g < NUM_GPR; g++) begin
         if (RETIRE_I.long_mode || g < NUM_LEGACY_GPR) begin
            rec_new[W_GPR0 + g] = narrow(RETIRE_I.gpr[g], RETIRE_I.long_mode);
         end
      end
      rec_new[W_STATUS] = 64'(s.ovf) | (64'(s.buf_flag) << STAT_BUF_BIT);
      rec_new[W_DADDR] = narrow(RETIRE_I.data_addr, RETIRE_I.long_mode);
      rec_new[W_DSRC] = RETIRE_I.data_src;
      rec_new[W_LAT] = s.len[sel] ? 64'(s.lat_last) : 64'h0;

      case (s.fsm)
         ST_IDLE: begin
            if (|trig) begin
               next_s.armed[sel] = 1'b0;
               if (s.index != s.absmax) begin
                  next_s.rec = rec_new;
                  next_s.word = '0;
                  next_s.mem.addr = s.index;
                  next_s.mem.data = rec_new[0];
                  next_s.mem_write = 1'b1;
                  next_s.fsm = ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            if (MEM_READY_I) begin
               if (s.word == LAST_WORD) begin
                  next_s.mem_write = 1'b0;
                  next_s.fsm = ST_FINISH;
               end else begin
                  next_s.word = nxt_word;
                  next_s.mem.addr = s.mem.addr + WORD_STEP;
                  next_s.mem.data = s.rec[nxt_word];
               end
            end
         end
         ST_FINISH: begin
            next_s.index = new_index;
            if (new_index == s.thresh) begin
               buf_set = 1'b1;
               next_s.pmi = 1'b1;
            end
            for (int i = 0; i < NUM_CTR; i++) begin
               if (s.ovf[i] && s.sen[i]) begin
                  next_s.ctr[i] = s.rst_val[i];
                  next_s.armed[i] = 1'b0;
               end
            end
            next_s.fsm = ST_IDLE;
         end
         default: next_s.fsm = ST_IDLE;
      endcase

      // Hardware set wins over software clear
      next_s.ovf = (s.ovf & ~ovf_clr) | ovf_set;
      next_s.buf_flag = (s.buf_flag && !buf_clr) || buf_set;
   end
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         s <= '0;
         s.waitreq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign AVS_READDATA_O = s.rdata;
   assign AVS_WAITREQUEST_O = s.waitreq;
   assign MEM_WR_O = s.mem;
   assign MEM_WRITE_O = s.mem_write;
   assign PMI_O = s.pmi;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   sequence seq_start;
      s.fsm == ST_IDLE && (|trig) && s.index != s.absmax;
   endsequence
   sequence seq_last_word;
      s.fsm == ST_WRITE && MEM_READY_I && s.word == LAST_WORD;
   endsequence

   // Per-counter checks, so whichever counter the bench picks is covered
   for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr_chk
      chk_wrap_arm: assert property (@(posedge CLK_I) disable iff (SRST_I)
         s.evsel[c][EVSEL_EN_BIT] && EVENT_I[c] && (&s.ctr[c]) && s.sen[c] && !wr
         && s.fsm == ST_IDLE && !(|trig) |=> s.armed[c] && s.ctr[c] == '0 && !MEM_WRITE_O)
         else $error("wrap did not arm");
      chk_reload: assert property (@(posedge CLK_I) disable iff (SRST_I)
         s.fsm == ST_FINISH && s.ovf[c] && s.sen[c] && !wr
         |=> s.ctr[c] == $past(s.rst_val[c])) else $error("counter not reloaded");
   end
   chk_trigger_start: assert property (seq_start |=> MEM_WRITE_O
      && MEM_WR_O.addr == $past(s.index)) else $error("record not started");
   chk_full_drop: assert property (s.fsm == ST_IDLE && (|trig) && s.index == s.absmax
      |=> !MEM_WRITE_O && s.fsm == ST_IDLE) else $error("write into full buffer");
   chk_word_step: assert property (MEM_WRITE_O && MEM_READY_I && s.word != LAST_WORD
      |=> MEM_WR_O.addr == $past(MEM_WR_O.addr) + WORD_STEP) else $error("bad step");
   chk_index_hold: assert property (s.fsm == ST_WRITE && !wr |=> s.index == $past(s.index))
      else $error("index moved mid record");
   chk_index_adv: assert property (seq_last_word ##1 !wr
      |=> s.index == $past(s.index) + REC_STRIDE) else $error("index not advanced");
   chk_thresh_pmi: assert property (s.fsm == ST_FINISH && new_index == s.thresh
      |=> PMI_O && s.buf_flag ##1 !PMI_O) else $error("threshold not signalled");
   chk_narrow_mode: assert property (seq_start and !RETIRE_I.long_mode |=>
      s.rec[W_GPR0][63:32] == 32'h0 && s.rec[W_GPR0 + NUM_LEGACY_GPR] == 64'h0)
      else $error("upper bits not zeroed");
   chk_status_snap: assert property (seq_start |=> s.rec[W_STATUS][NUM_CTR-1:0]
      == $past(s.ovf)) else $error("status snapshot wrong");

endmodule // pes_sample_capture
`default_nettype wire

// ===== tb/pes_mem_model.sv
// Sample buffer memory model: takes record words with random stalls
`timescale 1ns/10ps
`default_nettype none
module pes_mem_model
   import pes_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Record write port
   input wire pes_mem_wr_t MEM_WR_I,
   input wire logic MEM_WRITE_I,
   output logic MEM_READY_O
);
   logic [63:0] mem [logic [63:0]];
   int n_words = 0;
   always @(posedge CLK_I) begin
      if (MEM_WRITE_I === 1'b1 && MEM_READY_O && !SRST_I) begin
         mem[MEM_WR_I.addr] = MEM_WR_I.data;
         n_words++;
      end
      MEM_READY_O <= SRST_I ? 1'b0 : ($urandom % 4 != 0);
   end
endmodule // pes_mem_model
`default_nettype wire

// ===== tb/precise_event_sample_capture_tb.sv
// Testbench for precise event sample capture: registers, arming, records
`timescale 1ns/10ps
`default_nettype none
module precise_event_sample_capture_tb;
   import pes_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wreq;
   logic [3:0] ev = 4'h0;
   logic [3:0] prec = 4'h0;
   pes_retire_t ret = '0;
   logic disp = 1'b0;
   logic wb = 1'b0;
   pes_mem_wr_t mwr;
   logic mwrite;
   logic mready;
   logic pmi;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int pmi_cnt = 0;
   int k;
   int j;
   int lat;
   logic lat_en = 1'b1;
   logic [31:0] v;
   logic [63:0] base = 64'h0000_1000_0000_0000;

   always #2.5 clk = ~clk;

   pes_sample_capture dut_u (.CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .EVENT_I(ev), .PRECISE_I(prec),
      .RETIRE_I(ret), .LOAD_DISPATCH_I(disp), .LOAD_WRITEBACK_I(wb), .MEM_WR_O(mwr),
      .MEM_WRITE_O(mwrite), .MEM_READY_I(mready), .PMI_O(pmi));

   pes_mem_model mem_u (.CLK_I(clk), .SRST_I(srst), .MEM_WR_I(mwr), .MEM_WRITE_I(mwrite),
      .MEM_READY_O(mready));

   task automatic test_done();
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (pmi === 1'b1) pmi_cnt++;
      if (cycles > 20000) begin
         miscompares++;
         $display("CHECK FAILED %0t timeout", $time);
         test_done();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr64(input logic [7:0] a, input logic [63:0] d);
      bus(a, 1'b1, d[31:0]);
      bus(a + 8'h04, 1'b1, d[63:32]);
   endtask

   function automatic logic [63:0] exp_word(input int w, input logic [63:0] st);
      int g;
      g = w - 2;
      case (w)
         0: return ret.flags;
         1: return ret.next_ip;
         18: return st;
         19: return ret.data_addr;
         20: return ret.data_src;
         21: return lat_en ? 64'(lat) : 64'h0;
         default: return (!ret.long_mode && g >= 8) ? 64'h0 :
            (ret.long_mode ? ret.gpr[g] : {32'h0, ret.gpr[g][31:0]});
      endcase
   endfunction

   // Wrap counter k, load a tagged latency, fire a precise event
   task automatic shoot(input logic [63:0] idx, input logic [63:0] st, input logic lm,
                        input logic full);
      int n0;
      n0 = mem_u.n_words;
      ret.long_mode <= lm;
      ret.flags <= {lm ? $urandom : 32'h0, $urandom};
      ret.next_ip <= {lm ? $urandom : 32'h0, $urandom};
      ret.data_addr <= {lm ? $urandom : 32'h0, $urandom};
      ret.data_src <= {32'h0, $urandom};
      for (int i = 0; i < NUM_GPR; i++) ret.gpr[i] <= {$urandom, $urandom};
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= 4'h0;
      disp <= 1'b1;
      @(posedge clk);
      disp <= 1'b0;
      repeat (lat - 1) @(posedge clk);
      wb <= 1'b1;
      @(posedge clk);
      wb <= 1'b0;
      bus(A_STAT_LO, 1'b0, 32'h0);
      chk(v[k], 1'b1, "ovf bit");
      chk(mem_u.n_words, n0, "early write");
      prec[k] <= 1'b1;
      @(posedge clk);
      prec <= 4'h0;
      for (int t = 0; t < 300 && mem_u.n_words < n0 + (full ? 0 : 22); t++) @(posedge clk);
      repeat (4) @(posedge clk);
      bus(A_INDEX, 1'b0, 32'h0);
      chk(v, full ? idx[31:0] : idx[31:0] + 32'hb0, "index");
      chk(mem_u.n_words, n0 + (full ? 0 : 22), "word count");
      for (int w = 0; w < 22 && !full; w++)
         chk(mem_u.mem[idx + 64'(8 * w)], exp_word(w, st), "word");
   endtask

   initial begin
      void'($urandom(32'hf176));
      k = $urandom % NUM_CTR;
      j = (k + 1) % NUM_CTR;
      lat = 4 + $urandom % 20;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      bus(A_CAP, 1'b1, 32'h0);
      bus(A_CAP, 1'b0, 32'h0);
      chk({v[11:8], v[6]}, 5'h03, "capability");
      bus(A_IDENT, 1'b0, 32'h0);
      chk({v[23:16], v[15:8], v[2]}, 17'h06009, "identity");
      bus(A_MISC, 1'b0, 32'h0);
      chk({v[12], v[7]}, 2'h1, "misc");
      bus(8'hfc, 1'b0, 32'h0);
      chk(v, 32'h0, "unmapped");
      // software programs buffer, selects and enables first
      wr64(A_BASE, base);
      wr64(A_INDEX, base);
      wr64(A_ABSMAX, base + 64'h1000);
      wr64(A_THRESH, base + 64'hb0);
      wr64(A_RST0 + 8'(8 * k), 64'h0000_ffff_ffff_ffff);
      wr64(A_CTR0 + 8'(8 * k), 64'h0000_ffff_ffff_ffff);
      wr64(A_CTR0 + 8'(8 * j), 64'h5);
      bus(A_EVSEL0 + 8'(4 * k), 1'b1, 32'h0040_0000);
      bus(A_SEN_LO, 1'b1, 32'(1 << k));
      bus(A_SEN_HI, 1'b1, 32'hf);
      shoot(base, 64'(1 << k), 1'b1, 1'b0);
      chk(pmi_cnt, 1, "threshold pulse");
      bus(A_STAT_HI, 1'b0, 32'h0);
      chk(v[30], 1'b1, "buffer flag");
      bus(A_CTR0 + 8'(8 * k), 1'b0, 32'h0);
      chk(v, 32'hffff_ffff, "reload");
      bus(A_CTR0 + 8'(8 * j), 1'b0, 32'h0);
      chk(v, 32'h5, "untouched");
      // Latency word must read zero once latency recording is off
      bus(A_SEN_HI, 1'b1, 32'h0);
      lat_en = 1'b0;
      shoot(base + 64'hb0, 64'(1 << k) | 64'h4000_0000_0000_0000, 1'b0, 1'b0);
      wr64(A_ABSMAX, base + 64'h160);
      shoot(base + 64'h160, 64'h0, 1'b1, 1'b1);
      chk(pmi_cnt, 1, "no extra pulse");
      test_done();
   end
endmodule // precise_event_sample_capture_tb
`default_nettype wire
